// ===== design/uoif_defs.vh
// Constants for the USB on-the-go interrupt flag block: offsets, bit positions, timing counts.
// Assumes a 50 MHz module clock and a classic Wishbone register bus with 16-bit data.
// Function
// R1: Set cable identity change flag when sampled identity pin differs from last value.
// R2: One millisecond timer sets millisecond tick flag, bit 6, on each expiry.
// R3: Set line stable flag when line state held 1 ms and differs from last.
// R4: Set bus activity flag on data line or supply line activity.
// R5: Set session valid change flag when supply crosses A session threshold.
// R6: Set B session end change flag when supply crosses B session end threshold.
// R7: Set A supply valid change flag when supply crosses A supply valid threshold.
// R8: Supply threshold flags set on rising and falling crossings alike.
// R9: On-the-go enable register, one bit per flag, read-write, zero at reset.
// R10: Flags clear only by writing one to their bit, whole word write.
// R11: Set halt handshake flag when a stall handshake is sent.
// R12: Set wakeup flag after K-state held 2.5 us; K polarity depends on speed.
// R13: Set bus quiet flag after idle state held 3 ms or longer.
// R14: Set token done flag at token end; clearing it advances status queue.
// R15: Set frame start flag on received frame token or host threshold.
// R16: Set summary error flag only for errors enabled in error enable register.
// R17: Device role: bus reset flag after 2.5 us reset, once per reset.
// R18: Host role: arrival flag when not SE0 and no activity for 2.5 us.
// R19: Host role: removal flag bit 0 on detach, once until reset state clears.
// R20: Bus status shares one address; bit 0 reset or removal; bit 6 host only.
// R21: Bus enable register read-write, zero at reset; arrival enable reads zero in device role.
// R22: Interrupt request asserted while any flag and its enable are both set.
`ifndef UOIF_DEFS_VH
`define UOIF_DEFS_VH

// Register byte addresses (index times four, printed offsets are not word aligned)
`define UOIF_IDX_OTG_STATUS 12'h0600
`define UOIF_IDX_OTG_ENABLE 12'h0602
`define UOIF_IDX_BUS_STATUS 12'h060A
`define UOIF_IDX_BUS_ENABLE 12'h060C
`define UOIF_ADR_OTG_STATUS 14'h1800
`define UOIF_ADR_OTG_ENABLE 14'h1808
`define UOIF_ADR_BUS_STATUS 14'h1828
`define UOIF_ADR_BUS_ENABLE 14'h1830

// Implemented bits and reset values
`define UOIF_OTG_MASK 8'hFD
`define UOIF_BUS_MASK 8'hFF
`define UOIF_RESET_VAL 8'h00

// On-the-go flag positions
`define UOIF_B_IDENT 7
`define UOIF_B_MSEC 6
`define UOIF_B_LSTABLE 5
`define UOIF_B_ACTIV 4
`define UOIF_B_SESSVD 3
`define UOIF_B_SESEND 2
`define UOIF_B_VBUSVD 0

// Bus flag positions
`define UOIF_B_HALT 7
`define UOIF_B_ARRIVE 6
`define UOIF_B_WAKE 5
`define UOIF_B_QUIET 4
`define UOIF_B_TOKEN 3
`define UOIF_B_FRAME 2
`define UOIF_B_ERROR 1
`define UOIF_B_RESET 0

// Timing: clock in kHz, times as printed
`define UOIF_CLK_KHZ 50000
`define UOIF_MSEC_MS 1
`define UOIF_QUIET_MS 3
`define UOIF_SHORT_NS 2500
// Least times round up to whole cycles
`define UOIF_MSEC_CYC (`UOIF_MSEC_MS * `UOIF_CLK_KHZ)
`define UOIF_QUIET_CYC (`UOIF_QUIET_MS * `UOIF_CLK_KHZ)
`define UOIF_SHORT_CYC ((`UOIF_SHORT_NS * (`UOIF_CLK_KHZ / 1000) + 999) / 1000)

`endif

// ===== design/uoif_hold_timer.v
// Counts cycles a condition has held; pulses once when the least hold time is reached.
// Assumes the condition is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module uoif_hold_timer #(
    parameter integer HOLD_CYC = 125
) (
    input wire clk_i, // Module clock
    input wire rst_i, // Synchronous reset, active high
    input wire cond_i, // Condition being timed
    output reg hit_o // One-cycle pulse when the hold time is reached
);
    reg [17:0] cnt_r;
    reg done_r;

    // Count while the condition holds; fire once per continuous run
    always @(posedge clk_i)
    begin
        if (rst_i || !cond_i)
        begin
            cnt_r <= 18'h0_0000;
            done_r <= 1'b0;
            hit_o <= 1'b0;
        end
        else if (!done_r && cnt_r == HOLD_CYC[17:0] - 18'h0_0001)
        begin
            done_r <= 1'b1;
            hit_o <= 1'b1;
        end
        else
        begin
            hit_o <= 1'b0;
            if (!done_r)
                cnt_r <= cnt_r + 18'h0_0001;
        end
    end
endmodule // uoif_hold_timer
`default_nettype wire

// ===== design/uoif_flag_reg.v
// Eight sticky flags with write-one-to-clear; a set in the same cycle wins over the clear.
// Assumes set pulses are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module uoif_flag_reg #(
    parameter [7:0] MASK = 8'hFF
) (
    input wire clk_i, // Module clock
    input wire rst_i, // Synchronous reset, active high
    input wire [7:0] set_i, // Hardware set pulses
    input wire [7:0] clr_i, // Write-one-to-clear bits, valid on a full write
    output reg [7:0] flag_o // Sticky flags
);
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_bit
            // Per-bit sticky flag, unimplemented bits stay zero
            always @(posedge clk_i)
            begin
                if (rst_i || !MASK[g])
                    flag_o[g] <= 1'b0;
                else if (set_i[g])
                    flag_o[g] <= 1'b1;
                else if (clr_i[g])
                    flag_o[g] <= 1'b0; // R10
            end
        end
    endgenerate
endmodule // uoif_flag_reg
`default_nettype wire

// ===== design/uoif_top.v
// Interrupt flag and enable logic of a dual-role USB module, with a classic Wishbone slave.
// Assumes all line and event inputs are synchronous to clk_i and event inputs are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "uoif_defs.vh"
module uoif_top (
    input wire clk_i, // Module clock, 50 MHz
    input wire rst_i, // Synchronous reset, active high
    input wire [13:0] adr_i, // Wishbone byte address
    input wire [15:0] dat_i, // Wishbone write data
    output reg [15:0] dat_o, // Wishbone read data
    input wire we_i, // Wishbone write enable
    input wire [1:0] sel_i, // Wishbone byte selects
    input wire cyc_i, // Wishbone cycle
    input wire stb_i, // Wishbone strobe
    output reg ack_o, // Wishbone acknowledge
    input wire host_mode_i, // High in host role, low in device role
    input wire low_speed_i, // High when the link runs at low speed
    input wire ident_pin_i, // Sampled cable identity pin
    input wire se0_i, // Single-ended zero on the data lines
    input wire j_level_indication_i, // J-state on the data lines
    input wire line_activity_i, // Activity seen on the data lines
    input wire supply_activity_i, // Activity seen on the supply line
    input wire sess_valid_i, // Supply above A session threshold
    input wire sess_end_i, // Supply below B session end threshold
    input wire vbus_valid_i, // Supply above A supply valid threshold
    input wire stall_sent_i, // Pulse: stall handshake sent
    input wire token_done_i, // Pulse: token processing finished
    input wire frame_token_i, // Pulse: frame token received (device role)
    input wire frame_thresh_i, // Pulse: frame threshold reached (host role)
    input wire [7:0] error_flags_i, // Pulses of individual error conditions
    input wire [7:0] error_event_enable_i, // Error enable bits from the error enable register
    input wire detach_i, // Pulse: peripheral removal detected (host role)
    output reg queue_advance_o, // Pulse: advance transfer status queue
    output reg irq_o // Module interrupt request, active high
);
    reg [7:0] otg_event_enable_r;
    reg [7:0] bus_event_enable_r;
    wire [7:0] otg_event_status;
    wire [7:0] bus_event_status;
    reg [7:0] otg_set_nxt;
    reg [7:0] bus_set_nxt;
    reg [7:0] otg_clr_nxt;
    reg [7:0] bus_clr_nxt;
    reg [7:0] bus_en_view;
    reg ident_r;
    reg [1:0] line_r;
    reg [1:0] stable_line_r;
    reg sess_valid_r;
    reg sess_end_r;
    reg vbus_valid_r;
    reg [15:0] msec_cnt_r;
    reg msec_tick_r;
    reg reset_held_r;
    reg removal_held_r;
    wire line_stable_hit;
    wire wake_hit;
    wire quiet_hit;
    wire reset_hit;
    wire arrive_hit;
    wire bus_req;
    wire full_wr;
    wire k_state;
    wire bus_activity;
    wire line_changed;

    // Wishbone request decode; flags clear only on a full-word write
    assign bus_req = cyc_i && stb_i && !ack_o;
    assign full_wr = bus_req && we_i && (sel_i == 2'b11); // R10

    // K-state: differential one at low speed, differential zero at full speed
    assign k_state = !se0_i && (low_speed_i ? j_level_indication_i : !j_level_indication_i); // R12
    assign bus_activity = line_activity_i || supply_activity_i;
    assign line_changed = (line_r != {se0_i, j_level_indication_i});

    // Previous-value capture for edge and crossing detection
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ident_r <= 1'b1;
            line_r <= 2'b00;
            stable_line_r <= 2'b00;
            sess_valid_r <= 1'b0;
            sess_end_r <= 1'b0;
            vbus_valid_r <= 1'b0;
        end
        else
        begin
            ident_r <= ident_pin_i;
            line_r <= {se0_i, j_level_indication_i};
            sess_valid_r <= sess_valid_i;
            sess_end_r <= sess_end_i;
            vbus_valid_r <= vbus_valid_i;
            if (line_stable_hit)
                stable_line_r <= line_r; // R3
        end
    end

    // Free-running one millisecond timer
    always @(posedge clk_i)
    begin
        if (rst_i || msec_tick_r)
        begin
            msec_cnt_r <= 16'h0000;
        end
        else
        begin
            msec_cnt_r <= msec_cnt_r + 16'h0001;
        end
    end

    // Tick on timer expiry
    always @(posedge clk_i)
    begin
        if (rst_i)
            msec_tick_r <= 1'b0;
        else
            msec_tick_r <= (msec_cnt_r == `UOIF_MSEC_CYC - 2); // R2
    end

    // Line state held unchanged for 1 ms
    uoif_hold_timer #(.HOLD_CYC(`UOIF_MSEC_CYC)) u_lstable (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(!line_changed),
        .hit_o(line_stable_hit)
    );

    // K-state held for 2.5 us
    uoif_hold_timer #(.HOLD_CYC(`UOIF_SHORT_CYC)) u_wake (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(k_state),
        .hit_o(wake_hit)
    );

    // Idle (J-state, no SE0, no activity) held for 3 ms
    uoif_hold_timer #(.HOLD_CYC(`UOIF_QUIET_CYC)) u_quiet (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(!se0_i && j_level_indication_i && !bus_activity),
        .hit_o(quiet_hit)
    );

    // Bus reset (SE0) held for 2.5 us in device role
    uoif_hold_timer #(.HOLD_CYC(`UOIF_SHORT_CYC)) u_reset (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(se0_i && !host_mode_i),
        .hit_o(reset_hit)
    );

    // Not SE0 and no activity for 2.5 us in host role
    uoif_hold_timer #(.HOLD_CYC(`UOIF_SHORT_CYC)) u_arrive (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(!se0_i && !bus_activity && host_mode_i),
        .hit_o(arrive_hit)
    );

    // Reset and removal lockouts end when the reset state clears
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reset_held_r <= 1'b0;
            removal_held_r <= 1'b0;
        end
        else
        begin
            if (!se0_i)
                reset_held_r <= 1'b0; // R17
            else if (reset_hit)
                reset_held_r <= 1'b1;
            if (!se0_i)
                removal_held_r <= 1'b0; // R19
            else if (detach_i && host_mode_i)
                removal_held_r <= 1'b1;
        end
    end

    // On-the-go flag set terms
    always @*
    begin
        otg_set_nxt = 8'h00;
        otg_set_nxt[`UOIF_B_IDENT] = (ident_pin_i != ident_r); // R1
        otg_set_nxt[`UOIF_B_MSEC] = msec_tick_r; // R2
        otg_set_nxt[`UOIF_B_LSTABLE] = line_stable_hit && (line_r != stable_line_r); // R3
        otg_set_nxt[`UOIF_B_ACTIV] = bus_activity; // R4
        otg_set_nxt[`UOIF_B_SESSVD] = (sess_valid_i != sess_valid_r); // R5 R8
        otg_set_nxt[`UOIF_B_SESEND] = (sess_end_i != sess_end_r); // R6 R8
        otg_set_nxt[`UOIF_B_VBUSVD] = (vbus_valid_i != vbus_valid_r); // R7 R8
    end

    // Bus flag set terms; bits 0, 2 and 6 depend on role
    always @*
    begin
        bus_set_nxt = 8'h00;
        bus_set_nxt[`UOIF_B_HALT] = stall_sent_i; // R11
        bus_set_nxt[`UOIF_B_ARRIVE] = arrive_hit; // R18 R20
        bus_set_nxt[`UOIF_B_WAKE] = wake_hit; // R12
        bus_set_nxt[`UOIF_B_QUIET] = quiet_hit; // R13
        bus_set_nxt[`UOIF_B_TOKEN] = token_done_i; // R14
        bus_set_nxt[`UOIF_B_FRAME] = host_mode_i ? frame_thresh_i : frame_token_i; // R15
        bus_set_nxt[`UOIF_B_ERROR] = |(error_flags_i & error_event_enable_i); // R16
        if (host_mode_i)
            bus_set_nxt[`UOIF_B_RESET] = detach_i && !removal_held_r; // R19 R20
        else
            bus_set_nxt[`UOIF_B_RESET] = reset_hit && !reset_held_r; // R17 R20
    end

    // Write-one-to-clear terms per status register
    always @*
    begin
        otg_clr_nxt = 8'h00;
        bus_clr_nxt = 8'h00;
        if (full_wr && adr_i == `UOIF_ADR_OTG_STATUS)
            otg_clr_nxt = dat_i[7:0]; // R10
        if (full_wr && adr_i == `UOIF_ADR_BUS_STATUS)
            bus_clr_nxt = dat_i[7:0]; // R10
    end

    uoif_flag_reg #(.MASK(`UOIF_OTG_MASK)) u_otg_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(otg_set_nxt),
        .clr_i(otg_clr_nxt),
        .flag_o(otg_event_status)
    );

    uoif_flag_reg #(.MASK(`UOIF_BUS_MASK)) u_bus_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(bus_set_nxt),
        .clr_i(bus_clr_nxt),
        .flag_o(bus_event_status)
    );

    // Arrival enable is hidden in device role
    always @*
    begin
        bus_en_view = bus_event_enable_r;
        if (!host_mode_i)
            bus_en_view[`UOIF_B_ARRIVE] = 1'b0; // R21
    end

    // Enable registers, byte lane 0 carries the implemented bits
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            otg_event_enable_r <= `UOIF_RESET_VAL; // R9
            bus_event_enable_r <= `UOIF_RESET_VAL; // R21
        end
        else if (bus_req && we_i && sel_i[0])
        begin
            if (adr_i == `UOIF_ADR_OTG_ENABLE)
                otg_event_enable_r <= dat_i[7:0] & `UOIF_OTG_MASK; // R9
            if (adr_i == `UOIF_ADR_BUS_ENABLE)
                bus_event_enable_r <= dat_i[7:0]; // R21
        end
    end

    // Wishbone answer: one wait state, unmapped reads return zero
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 16'h0000;
        end
        else
        begin
            ack_o <= bus_req;
            dat_o <= 16'h0000;
            if (bus_req && !we_i)
            begin
                case (adr_i)
                    `UOIF_ADR_OTG_STATUS: dat_o <= {8'h00, otg_event_status};
                    `UOIF_ADR_OTG_ENABLE: dat_o <= {8'h00, otg_event_enable_r};
                    `UOIF_ADR_BUS_STATUS: dat_o <= {8'h00, bus_event_status};
                    `UOIF_ADR_BUS_ENABLE: dat_o <= {8'h00, bus_en_view};
                    default: dat_o <= 16'h0000;
                endcase
            end
        end
    end

    // Queue advance on clearing the token done flag; interrupt request
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            queue_advance_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            queue_advance_o <= bus_clr_nxt[`UOIF_B_TOKEN] && bus_event_status[`UOIF_B_TOKEN]; // R14
            irq_o <= |(otg_event_status & otg_event_enable_r) || |(bus_event_status & bus_en_view); // R22
        end
    end
endmodule // uoif_top
`default_nettype wire

// ===== verification/uoif_link_peer.sv
// Link peer model: drives the line state that the flag block watches.
// Assumes the bench picks the state; levels change just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module uoif_link_peer (
    input wire logic clk_i, // Module clock
    input wire logic [1:0] mode_i, // 0 idle J, 1 K, 2 SE0, 3 traffic
    output logic se0_o, // Single-ended zero
    output logic j_o, // J-state
    output logic act_o // Data line activity
);
    // Line levels follow the state; traffic toggles J every cycle
    always @(posedge clk_i)
    begin
        se0_o <= (mode_i == 2'd2);
        j_o <= (mode_i == 2'd0) | ((mode_i == 2'd3) & ~j_o);
        act_o <= (mode_i == 2'd3);
    end
endmodule // uoif_link_peer
`default_nettype wire

// ===== verification/uoif_top_assertions.sv
// Checker for the flag block: bus answer, enable read-back, interrupt timing.
// Assumes it is bound to uoif_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "uoif_defs.vh"
module uoif_top_assertions (
    input wire clk_i, // Clock
    input wire rst_i, // Reset
    input wire [13:0] adr_i, // Address
    input wire [15:0] dat_i, // Write data
    input wire [15:0] dat_o, // Read data
    input wire we_i, // Write
    input wire [1:0] sel_i, // Selects
    input wire cyc_i, // Cycle
    input wire stb_i, // Strobe
    input wire ack_o, // Answer
    input wire host_mode_i, // Host role
    input wire line_activity_i, // Activity
    input wire stall_sent_i, // Stall
    input wire [7:0] error_flags_i, // Errors
    input wire [7:0] error_event_enable_i, // Error enables
    input wire queue_advance_o, // Queue step
    input wire irq_o // Request
);
    logic [7:0] oen_m;
    logic [7:0] ben_m;
    logic wr;
    logic clr_tok;
    logic rd_ack;
    assign wr = cyc_i && stb_i && we_i;
    assign rd_ack = cyc_i && stb_i && !we_i && ack_o;
    assign clr_tok = wr && adr_i == `UOIF_ADR_BUS_STATUS && dat_i[3] && sel_i == 2'b11;
    // Mirror of both enable registers, taken when a write is answered
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            oen_m <= 8'h00;
            ben_m <= 8'h00;
        end
        else if (wr && ack_o && sel_i[0])
        begin
            if (adr_i == `UOIF_ADR_OTG_ENABLE)
                oen_m <= dat_i[7:0];
            if (adr_i == `UOIF_ADR_BUS_ENABLE)
                ben_m <= dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_ONCE: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("answer not one cycle");
    AST_OEN_READ: assert property (rd_ack && adr_i == `UOIF_ADR_OTG_ENABLE |-> dat_o == {8'h00, oen_m & 8'hFD})
        else $error("otg enable read wrong");
    AST_BEN_READ: assert property (rd_ack && adr_i == `UOIF_ADR_BUS_ENABLE
        |-> dat_o == {8'h00, ben_m & ($past(host_mode_i) ? 8'hFF : 8'hBF)})
        else $error("bus enable read wrong");
    AST_ACT_IRQ: assert property (line_activity_i ##1 (oen_m[4] && !wr) |=> irq_o)
        else $error("activity gave no request");
    AST_STALL_IRQ: assert property (stall_sent_i ##1 (ben_m[7] && !wr) |=> irq_o)
        else $error("stall gave no request");
    AST_ERR_IRQ: assert property ((|(error_flags_i & error_event_enable_i)) ##1 (ben_m[1] && !wr) |=> irq_o)
        else $error("enabled error gave no request");
    AST_QUEUE: assert property (queue_advance_o |-> $past(clr_tok) || $past(clr_tok, 2))
        else $error("queue step without token clear");
    AST_QUIET: assert property ((oen_m == 8'h00 && ben_m == 8'h00) [*2] |-> !irq_o)
        else $error("request with all enables off");
    COV_STALL: cover property (stall_sent_i ##1 ben_m[7]);
    COV_QUEUE: cover property (queue_advance_o);
    COV_HOST_READ: cover property (rd_ack && host_mode_i);
endmodule // uoif_top_assertions
bind uoif_top uoif_top_assertions i_chk (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i,
    .ack_o, .host_mode_i, .line_activity_i, .stall_sent_i, .error_flags_i, .error_event_enable_i,
    .queue_advance_o, .irq_o);
`default_nettype wire

// ===== verification/tb.sv
// Bench for the flag block: registers, event flags, roles and the request.
// Assumes the link peer drives line state; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
`include "uoif_defs.vh"
module tb;
    localparam logic [13:0] OS = `UOIF_ADR_OTG_STATUS;
    localparam logic [13:0] OE = `UOIF_ADR_OTG_ENABLE;
    localparam logic [13:0] BS = `UOIF_ADR_BUS_STATUS;
    localparam logic [13:0] BE = `UOIF_ADR_BUS_ENABLE;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [13:0] adr_i = 14'h0000;
    logic [15:0] dat_i = 16'h0000;
    logic [1:0] sel_i = 2'b00;
    logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, host_mode_i = 1'b0, ident_pin_i = 1'b1;
    logic sess_valid_i = 1'b0, sess_end_i = 1'b0, vbus_valid_i = 1'b0, supply_activity_i = 1'b0;
    logic stall_sent_i = 1'b0, token_done_i = 1'b0, frame_token_i = 1'b0, frame_thresh_i = 1'b0;
    logic detach_i = 1'b0, ls = 1'b0;
    logic [15:0] n_qa = 16'h0000, qb = 16'h0000;
    logic [7:0] error_flags_i = 8'h00;
    logic [7:0] error_event_enable_i = 8'h01;
    logic [1:0] mode = 2'd0;
    logic [15:0] q;
    wire se0, jl, act, ack_o, queue_advance_o, irq_o;
    wire [15:0] dat_o;
    int fails = 0;
    int n_compared = 0;
    // Table rows: event code, register to read, expected flags
    int ev [11] = '{0, 1, 2, 3, 10, 4, 5, 6, 7, 7, 9};
    logic [13:0] ra [11] = '{BS, BS, BS, BS, BS, OS, OS, OS, OS, OS, OS};
    logic [15:0] ex [11] = '{16'h0080, 16'h0008, 16'h0004, 16'h0002, 16'h0000, 16'h0080, 16'h0008,
        16'h0004, 16'h0001, 16'h0001, 16'h0010};
    uoif_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
        .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .host_mode_i(host_mode_i), .low_speed_i(ls),
        .ident_pin_i(ident_pin_i), .se0_i(se0), .j_level_indication_i(jl), .line_activity_i(act),
        .supply_activity_i(supply_activity_i), .sess_valid_i(sess_valid_i), .sess_end_i(sess_end_i),
        .vbus_valid_i(vbus_valid_i), .stall_sent_i(stall_sent_i), .token_done_i(token_done_i),
        .frame_token_i(frame_token_i), .frame_thresh_i(frame_thresh_i), .error_flags_i(error_flags_i),
        .error_event_enable_i(error_event_enable_i), .detach_i(detach_i), .queue_advance_o(queue_advance_o),
        .irq_o(irq_o));
    uoif_link_peer i_peer (.clk_i(clk_i), .mode_i(mode), .se0_o(se0), .j_o(jl), .act_o(act));
    // 50 MHz clock
    initial forever #10 clk_i = ~clk_i;
    // Count queue step pulses
    always @(posedge clk_i)
        if (queue_advance_o)
            n_qa <= n_qa + 16'h0001;
    task automatic final_report;
        $display("fails=%0d n_compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s exp=%h got=%h", what, e, s);
        end
    endtask
    // One classic cycle; held until ack is sampled, then released for a cycle
    task automatic wb(input logic w, input logic [13:0] a, input logic [15:0] d, input logic [1:0] s);
        int n;
        n = 0;
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
        if (n >= 20)
        begin
            fails++;
            final_report();
        end
    endtask
    task automatic rd(input logic [13:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0000, 2'b11);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic wr(input logic [13:0] a, input logic [15:0] d);
        wb(1'b1, a, d, 2'b11);
    endtask
    task automatic irq(input logic e);
        chk("irq", {15'h0000, e}, {15'h0000, irq_o});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One event of the given code, then time for flag and request
    task automatic pulse(input int c);
        case (c)
            0: stall_sent_i <= 1'b1;
            1: token_done_i <= 1'b1;
            2: frame_token_i <= 1'b1;
            3: error_flags_i <= 8'h01;
            4: ident_pin_i <= ~ident_pin_i;
            5: sess_valid_i <= ~sess_valid_i;
            6: sess_end_i <= ~sess_end_i;
            7: vbus_valid_i <= ~vbus_valid_i;
            8: detach_i <= 1'b1;
            9: supply_activity_i <= 1'b1;
            10: error_flags_i <= 8'h02;
            default: frame_thresh_i <= 1'b1;
        endcase
        @(posedge clk_i);
        {stall_sent_i, token_done_i, frame_token_i, detach_i, supply_activity_i, frame_thresh_i} <= 6'h00;
        error_flags_i <= 8'h00;
        wt(3);
    endtask
    initial
    begin
        wt(4);
        rst_i <= 1'b0;
        rd(OS, 16'h0000);
        rd(OE, 16'h0000);
        rd(BS, 16'h0000);
        rd(BE, 16'h0000);
        rd(14'h1804, 16'h0000);
        wr(OE, 16'hFFFF);
        rd(OE, 16'h00FD);
        wr(BE, 16'hFFFF);
        rd(BE, 16'h00BF);
        host_mode_i <= 1'b1;
        rd(BE, 16'h00FF);
        host_mode_i <= 1'b0;
        wr(OS, 16'h00FF);
        wr(BS, 16'h00FF);
        for (int i = 0; i < 11; i++)
        begin
            qb = n_qa;
            pulse(ev[i]);
            rd(ra[i], ex[i]);
            wr(ra[i], 16'h00FF);
            wt(2);
            chk("queue step", {15'h0000, ev[i] == 1}, n_qa - qb);
            rd(ra[i], 16'h0000);
        end
        // Narrow write must not clear
        pulse(0);
        wb(1'b1, BS, 16'h0080, 2'b01);
        rd(BS, 16'h0080);
        wr(BS, 16'h0080);
        // Request follows flag and enable
        wr(OE, 16'h0000);
        wr(BE, 16'h0080);
        pulse(0);
        irq(1'b1);
        wr(BS, 16'h0080);
        wt(2);
        irq(1'b0);
        wr(BE, 16'h0000);
        pulse(0);
        irq(1'b0);
        wr(BS, 16'h00FF);
        // Bus reset in device role, once per reset state
        mode <= 2'd2;
        wt(130);
        rd(BS, 16'h0001);
        wr(BS, 16'h00FF);
        wt(130);
        rd(BS, 16'h0000);
        mode <= 2'd1;
        wt(130);
        mode <= 2'd0;
        rd(BS, 16'h0020);
        wr(BS, 16'h00FF);
        // Low speed: a high differential level is the K-state
        ls <= 1'b1;
        wt(130);
        rd(BS, 16'h0020);
        ls <= 1'b0;
        wr(BS, 16'h00FF);
        // Host role: arrival, removal lockout, frame threshold
        host_mode_i <= 1'b1;
        wt(130);
        rd(BS, 16'h0040);
        wr(BS, 16'h00FF);
        mode <= 2'd2;
        wt(3);
        pulse(8);
        rd(BS, 16'h0001);
        wr(BS, 16'h00FF);
        pulse(8);
        rd(BS, 16'h0000);
        mode <= 2'd0;
        wt(3);
        pulse(8);
        pulse(11);
        rd(BS, 16'h0005);
        wr(BS, 16'h00FF);
        // Line traffic, then a quiet millisecond
        wr(OE, 16'h0010);
        wr(OS, 16'h00FF);
        mode <= 2'd3;
        wt(3);
        mode <= 2'd0;
        wt(3);
        rd(OS, 16'h0010);
        wr(OS, 16'h00FF);
        wt(50000);
        rd(OS, 16'h0060);
        // Reset in mid-run clears enables and flags
        rst_i <= 1'b1;
        wt(2);
        rst_i <= 1'b0;
        rd(OE, 16'h0000);
        rd(BS, 16'h0000);
        final_report();
    end
endmodule // tb
`default_nettype wire
